// *** hdl/monitor_alert_consts.svh ***
`ifndef MONITOR_ALERT_CONSTS_SVH
`define MONITOR_ALERT_CONSTS_SVH

// Register offsets
`define ADDR_VLIM_FIRST 8'h2B
`define ADDR_VLIM_LAST  8'h32
`define ADDR_THOT       8'h39
`define ADDR_THYST      8'h3A
`define ADDR_CFG        8'h40
`define ADDR_STAT       8'h41
`define ADDR_MASK       8'h43
`define ADDR_TCFG       8'h4B

// Configuration fields
`define CFG_RUN_BIT     0
`define CFG_AEN_BIT     1
`define CFG_ACLR_BIT    3
`define CFG_LINE50_BIT  4
`define CFG_SHORT_BIT   5
`define CFG_SRST_BIT    7
`define CFG_WMASK       8'hBB
`define CFG_RST         8'h08

// Status and mask layout
`define STAT_TEMP_BIT   4
`define NUM_VCHAN       4
`define NUM_CHAN        5
`define FLAG_MASK       8'h1F
`define STAT_RST        8'h00
`define MASK_RST        8'h00
`define TCFG_WMASK      8'h03
`define TCFG_RST        8'h00

// Limit defaults: nominal code 192, 1.1x and 0.9x rounded down
`define THOT_RST        8'h50
`define THYST_RST       8'h41
`define VHIGH_RST       8'hD3
`define VLOW_RST        8'hAC

// Conversion timing
`define CLK_HZ          10000000
`define CONV_TEMP_MS    66
`define CONV_VOLT_MS    33
`define CONV_TEMP_CYC   (`CONV_TEMP_MS * (`CLK_HZ / 1000))
`define CONV_VOLT_CYC   (`CONV_VOLT_MS * (`CLK_HZ / 1000))
`define OSC60_HZ_X10    614
`define OSC50_HZ_X10    512
`define SHORT_SHIFT     2
`define TIMER_W         24

`endif

// *** hdl/mac_pkg.sv ***
package mac_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    TMODE_DEFAULT,
    TMODE_ONCE,
    TMODE_COMPARE
  } temp_mode_t;

  typedef enum logic {
    SEQ_IDLE,
    SEQ_CONVERT
  } seq_state_t;

endpackage : mac_pkg

// *** hdl/limit_window.sv ***
module limit_window #(
  parameter int W      = 8,
  parameter bit SIGNED = 1'b0
) (
  input  logic [W-1:0] code_i,
  input  logic [W-1:0] low_i,
  input  logic [W-1:0] high_i,
  output logic         below_o,
  output logic         above_o
);

  always_comb begin
    if (SIGNED) begin
      below_o = $signed(code_i) < $signed(low_i);
      above_o = $signed(code_i) > $signed(high_i);
    end else begin
      below_o = code_i < low_i;
      above_o = code_i > high_i;
    end
  end

endmodule : limit_window

// *** hdl/monitor_alert_control.sv ***
// Overview of operation
// - Config bit 0 cleared stops the measurement loop and enters shutdown.
// - Register port keeps serving reads and writes while shut down.
// - Config bit 0 set starts the repeating cycle over all inputs.
// - Config bit 1 gates the alert pin; zero keeps it released.
// - Config bit 3 releases the alert pin, status stays untouched.
// - Loop stays stopped while config bit 3 is one; reset value 08h.
// - Config bit 4 picks 51.2kHz instead of 61.4kHz conversion clock.
// - Config bit 5 shortens each conversion to a quarter.
// - Config bit 7 restores every register to defaults, itself included.
// - Status bits 0-3 flag 2.5V, 1.8V, 5V, supply; bit 4 temperature.
// - Status bit sets when a measurement crosses its high or low limit.
// - Voltage out of window asserts alert; limits live at 2Bh-32h.
// - Temperature bit setting and clearing follow the temperature mode field.
// - Default and one-time modes: status read clears until next fault.
// - Mask bit one suppresses that status bit and its alert.
// - Hot limit resets to 50h, hysteresis limit to 41h.
// - Voltage limits reset to 1.1 and 0.9 times nominal code.
// - Mode field: 00 and 11 default, 01 one-time, 10 comparator.
// - Comparator mode: read keeps temperature bit when its fault persists, else clears all.
// - Persisting fault reasserts alert at the end of next conversion, except temperature in one-time mode.
`include "monitor_alert_consts.svh"

module monitor_alert_control #(
  parameter int TEMP_CYC = `CONV_TEMP_CYC,
  parameter int VOLT_CYC = `CONV_VOLT_CYC
) (
  input  logic              mclk_i,
  input  logic              rst_i,
  input  mac_pkg::reg_req_t reg_req_i,
  output logic [7:0]        rdata_o,
  output logic              rvalid_o,
  input  logic [7:0]        meas_code_i,
  output logic [2:0]        conv_chan_o,
  output logic              conv_active_o,
  output logic              osc_slow_o,
  output logic              short_cycle_o,
  output logic              shutdown_o,
  output logic              alert_o,
  output logic              alert_oe_o
);

  localparam int TEMP_CYC_50 = TEMP_CYC * `OSC60_HZ_X10 / `OSC50_HZ_X10;
  localparam int VOLT_CYC_50 = VOLT_CYC * `OSC60_HZ_X10 / `OSC50_HZ_X10;

  logic [7:0]          cfg_r;
  logic [7:0]          status_r;
  logic [7:0]          mask_r;
  logic [7:0]          tcfg_r;
  logic [7:0]          thot_r;
  logic [7:0]          thyst_r;
  logic [7:0]          vlim_r [2*`NUM_VCHAN];
  mac_pkg::seq_state_t state_r;
  logic [2:0]          chan_r;
  logic [`TIMER_W-1:0] timer_r;
  logic                conv_active_r;
  logic                meas_done_r;
  logic [2:0]          meas_chan_r;
  logic [7:0]          meas_code_r;
  logic                temp_hot_r;
  logic                temp_now_r;
  logic [`NUM_CHAN-1:0] below_w;
  logic [`NUM_CHAN-1:0] above_w;
  logic [7:0]          lo_w [`NUM_CHAN];
  logic [7:0]          hi_w [`NUM_CHAN];
  logic [7:0]          set_w;
  logic [7:0]          clr_w;
  logic [7:0]          status_nxt;
  logic                soft_rst;
  logic                run;
  logic                stat_rd;
  mac_pkg::temp_mode_t tmode;

  function automatic mac_pkg::temp_mode_t mode_of(input logic [1:0] f);
    unique case (f)
      2'b01:   mode_of = mac_pkg::TMODE_ONCE;
      2'b10:   mode_of = mac_pkg::TMODE_COMPARE;
      default: mode_of = mac_pkg::TMODE_DEFAULT;
    endcase
  endfunction : mode_of

  function automatic logic [`TIMER_W-1:0] conv_len(input logic [2:0] ch,
                                                  input logic       slow,
                                                  input logic       short);
    int n;
    n = (ch == 3'(`NUM_VCHAN)) ? (slow ? TEMP_CYC_50 : TEMP_CYC)
                               : (slow ? VOLT_CYC_50 : VOLT_CYC);
    if (short) begin
      n = n >> `SHORT_SHIFT;
    end
    if (n < 1) begin
      n = 1;
    end
    conv_len = `TIMER_W'(n);
  endfunction : conv_len

  function automatic logic is_addr(input mac_pkg::reg_req_t q, input logic [7:0] a);
    is_addr = (q.addr == a);
  endfunction : is_addr

  assign soft_rst = reg_req_i.wr && is_addr(reg_req_i, `ADDR_CFG)
                    && reg_req_i.wdata[`CFG_SRST_BIT];
  assign run      = cfg_r[`CFG_RUN_BIT] && !cfg_r[`CFG_ACLR_BIT];
  assign stat_rd  = reg_req_i.rd && is_addr(reg_req_i, `ADDR_STAT);
  assign tmode    = mode_of(tcfg_r[1:0]);

  // Configuration, mask and temperature mode
  always_ff @(posedge mclk_i) begin
    if (rst_i || soft_rst) begin
      cfg_r  <= `CFG_RST;
      mask_r <= `MASK_RST;
      tcfg_r <= `TCFG_RST;
    end else if (reg_req_i.wr) begin
      if (is_addr(reg_req_i, `ADDR_CFG)) begin
        cfg_r <= reg_req_i.wdata & `CFG_WMASK;
      end
      if (is_addr(reg_req_i, `ADDR_MASK)) begin
        mask_r <= reg_req_i.wdata & `FLAG_MASK;
      end
      if (is_addr(reg_req_i, `ADDR_TCFG)) begin
        tcfg_r <= reg_req_i.wdata & `TCFG_WMASK;
      end
    end
  end

  // Limit registers
  always_ff @(posedge mclk_i) begin
    if (rst_i || soft_rst) begin
      thot_r  <= `THOT_RST;
      thyst_r <= `THYST_RST;
      for (int i = 0; i < 2*`NUM_VCHAN; i++) begin
        vlim_r[i] <= i[0] ? `VLOW_RST : `VHIGH_RST;
      end
    end else if (reg_req_i.wr) begin
      if (is_addr(reg_req_i, `ADDR_THOT)) begin
        thot_r <= reg_req_i.wdata;
      end
      if (is_addr(reg_req_i, `ADDR_THYST)) begin
        thyst_r <= reg_req_i.wdata;
      end
      if (reg_req_i.addr >= `ADDR_VLIM_FIRST && reg_req_i.addr <= `ADDR_VLIM_LAST) begin
        vlim_r[3'(reg_req_i.addr - `ADDR_VLIM_FIRST)] <= reg_req_i.wdata;
      end
    end
  end

  // Measurement sequencer; the ADC result is taken at the end of each window
  always_ff @(posedge mclk_i) begin
    if (rst_i || soft_rst) begin
      state_r       <= mac_pkg::SEQ_IDLE;
      chan_r        <= 3'h0;
      timer_r       <= '0;
      conv_active_r <= 1'b0;
      meas_done_r   <= 1'b0;
      meas_chan_r   <= 3'h0;
      meas_code_r   <= 8'h00;
    end else begin
      meas_done_r <= 1'b0;
      unique case (state_r)
        mac_pkg::SEQ_IDLE: begin
          if (run) begin
            state_r       <= mac_pkg::SEQ_CONVERT;
            chan_r        <= 3'h0;
            conv_active_r <= 1'b1;
            timer_r       <= conv_len(3'h0, cfg_r[`CFG_LINE50_BIT],
                                      cfg_r[`CFG_SHORT_BIT]);
          end
        end
        mac_pkg::SEQ_CONVERT: begin
          if (!run) begin
            state_r       <= mac_pkg::SEQ_IDLE;
            conv_active_r <= 1'b0;
          end else if (timer_r <= `TIMER_W'(1)) begin
            meas_done_r <= 1'b1;
            meas_chan_r <= chan_r;
            meas_code_r <= meas_code_i;
            chan_r      <= (chan_r == 3'(`NUM_CHAN - 1)) ? 3'h0 : chan_r + 3'h1;
            timer_r     <= conv_len((chan_r == 3'(`NUM_CHAN - 1)) ? 3'h0 : chan_r + 3'h1,
                                    cfg_r[`CFG_LINE50_BIT], cfg_r[`CFG_SHORT_BIT]);
          end else begin
            timer_r <= timer_r - `TIMER_W'(1);
          end
        end
      endcase
    end
  end

  // Window compare per input; temperature compares signed against hot and hysteresis
  genvar g;
  generate
    for (g = 0; g < `NUM_CHAN; g++) begin : g_win
      if (g < `NUM_VCHAN) begin : g_v
        assign hi_w[g] = vlim_r[2*g];
        assign lo_w[g] = vlim_r[2*g+1];
      end else begin : g_t
        assign hi_w[g] = thot_r;
        assign lo_w[g] = thyst_r;
      end
      limit_window #(
        .W      (8),
        .SIGNED (g == `NUM_VCHAN)
      ) u_win (
        .code_i  (meas_code_r),
        .low_i   (lo_w[g]),
        .high_i  (hi_w[g]),
        .below_o (below_w[g]),
        .above_o (above_w[g])
      );
    end
  endgenerate

  logic t_done;
  logic t_over;
  logic t_under;
  assign t_done  = meas_done_r && (meas_chan_r == 3'(`NUM_VCHAN));
  assign t_over  = above_w[`NUM_VCHAN];
  assign t_under = below_w[`NUM_VCHAN];

  always_comb begin
    set_w = 8'h00;
    clr_w = 8'h00;
    for (int i = 0; i < `NUM_VCHAN; i++) begin
      set_w[i] = meas_done_r && (meas_chan_r == 3'(i)) && (below_w[i] || above_w[i]);
    end
    if (t_done) begin
      unique case (tmode)
        mac_pkg::TMODE_DEFAULT: set_w[`STAT_TEMP_BIT] = t_over || (temp_hot_r && !t_under);
        mac_pkg::TMODE_ONCE:    set_w[`STAT_TEMP_BIT] = t_over ? !temp_hot_r
                                                               : (t_under && temp_hot_r);
        mac_pkg::TMODE_COMPARE: begin
          set_w[`STAT_TEMP_BIT] = t_over;
          clr_w[`STAT_TEMP_BIT] = !t_over;
        end
      endcase
    end
    if (stat_rd) begin
      clr_w = `FLAG_MASK;
      if (tmode == mac_pkg::TMODE_COMPARE && temp_now_r) begin
        clr_w[`STAT_TEMP_BIT] = 1'b0;
      end
    end
    // Set beats a clear in the same cycle
    status_nxt = (status_r & ~clr_w) | (set_w & ~mask_r);
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || soft_rst) begin
      status_r <= `STAT_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  // Hot tracking spans measurements for default and one-time modes
  always_ff @(posedge mclk_i) begin
    if (rst_i || soft_rst) begin
      temp_hot_r <= 1'b0;
      temp_now_r <= 1'b0;
    end else if (t_done) begin
      temp_now_r <= t_over;
      if (t_over) begin
        temp_hot_r <= 1'b1;
      end else if (t_under) begin
        temp_hot_r <= 1'b0;
      end
    end
  end

  // Open-drain alert; one cycle behind the status it reflects
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      alert_oe_o <= 1'b0;
      alert_o    <= 1'b0;
    end else begin
      alert_o    <= 1'b0;
      alert_oe_o <= cfg_r[`CFG_AEN_BIT] && !cfg_r[`CFG_ACLR_BIT]
                    && |(status_r & ~mask_r);
    end
  end

  // Register read port stays alive in shutdown
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= reg_req_i.rd;
      if (reg_req_i.rd) begin
        unique case (reg_req_i.addr)
          `ADDR_CFG:   rdata_o <= cfg_r;
          `ADDR_STAT:  rdata_o <= status_r;
          `ADDR_MASK:  rdata_o <= mask_r;
          `ADDR_TCFG:  rdata_o <= tcfg_r;
          `ADDR_THOT:  rdata_o <= thot_r;
          `ADDR_THYST: rdata_o <= thyst_r;
          default: begin
            if (reg_req_i.addr >= `ADDR_VLIM_FIRST && reg_req_i.addr <= `ADDR_VLIM_LAST) begin
              rdata_o <= vlim_r[3'(reg_req_i.addr - `ADDR_VLIM_FIRST)];
            end else begin
              rdata_o <= 8'h00;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || soft_rst) begin
      conv_chan_o   <= 3'h0;
      osc_slow_o    <= 1'b0;
      short_cycle_o <= 1'b0;
      shutdown_o    <= 1'b1;
    end else begin
      conv_chan_o   <= chan_r;
      osc_slow_o    <= cfg_r[`CFG_LINE50_BIT];
      short_cycle_o <= cfg_r[`CFG_SHORT_BIT];
      shutdown_o    <= !run;
    end
  end

  assign conv_active_o = conv_active_r;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  chk_stop_halts: assert property (!run |=> !conv_active_o)
    else $error("loop kept running while stopped");
  chk_bus_shutdown: assert property (reg_req_i.rd && shutdown_o |=> rvalid_o)
    else $error("read not answered in shutdown");
  chk_run_starts: assert property (run && state_r == mac_pkg::SEQ_IDLE && !soft_rst
    |=> conv_active_o && chan_r == 3'h0)
    else $error("loop did not start");
  chk_alert_gate: assert property (!cfg_r[`CFG_AEN_BIT] |=> !alert_oe_o)
    else $error("alert driven while disabled");
  chk_alert_clear: assert property (cfg_r[`CFG_ACLR_BIT] && !soft_rst
    |=> !alert_oe_o && status_r == $past(status_nxt))
    else $error("alert clear misbehaved");
  chk_clear_blocks: assert property (cfg_r[`CFG_ACLR_BIT] |=> !conv_active_o)
    else $error("loop ran with alert clear set");
  chk_soft_reset: assert property (soft_rst |=> cfg_r == `CFG_RST && status_r == `STAT_RST
    && thot_r == `THOT_RST)
    else $error("soft reset incomplete");
  chk_mask_status: assert property (((status_r & ~$past(status_r)) & $past(mask_r)) == 8'h00)
    else $error("masked status bit set");
  chk_vfault_sets: assert property (meas_done_r && meas_chan_r == 3'h0 && above_w[0] && !mask_r[0]
    |=> status_r[0] ##1 alert_oe_o || !$past(cfg_r[`CFG_AEN_BIT]) || $past(cfg_r[`CFG_ACLR_BIT]))
    else $error("voltage fault not flagged");
  chk_read_clears: assert property (stat_rd && set_w == 8'h00 && tmode != mac_pkg::TMODE_COMPARE
    && !soft_rst |=> status_r == 8'h00)
    else $error("status read did not clear");
  chk_cmp_keeps: assert property (stat_rd && tmode == mac_pkg::TMODE_COMPARE && temp_now_r
    && status_r[`STAT_TEMP_BIT] && !t_done && !soft_rst |=> status_r[`STAT_TEMP_BIT])
    else $error("comparator temp bit lost on read");
  chk_short_len: assert property (state_r == mac_pkg::SEQ_IDLE && run && cfg_r[`CFG_SHORT_BIT]
    && !cfg_r[`CFG_LINE50_BIT] && !soft_rst |=> timer_r == `TIMER_W'(VOLT_CYC >> `SHORT_SHIFT))
    else $error("short cycle length wrong");

  cov_start: cover property (shutdown_o ##1 conv_active_o);
  cov_temp_cmp: cover property (t_done && t_over && tmode == mac_pkg::TMODE_COMPARE);
  cov_read_clear: cover property (stat_rd && status_r != 8'h00);
  cov_soft_rst: cover property (soft_rst);

endmodule : monitor_alert_control

// *** testbench/adc_model.sv ***
module adc_model (
  input  logic            mclk_i,
  input  logic [2:0]      conv_chan_i,
  input  logic            conv_active_i,
  input  logic [4:0][7:0] codes_i,
  output logic [7:0]      meas_code_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] idle_r = 8'h00;
  // Idle output flips each cycle so a stray sample never looks like a held code
  always_ff @(posedge mclk_i) idle_r <= ~idle_r;
  assign meas_code_o = conv_active_i ? codes_i[conv_chan_i] : idle_r;
endmodule : adc_model

// *** testbench/monitor_alert_control_tb_top.sv ***
module monitor_alert_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TC = 40;
  localparam int VC = 20;
  localparam logic [7:0] RA [11] = '{8'h40, 8'h41, 8'h43, 8'h39, 8'h3A, 8'h2B, 8'h2C,
                                     8'h2D, 8'h32, 8'h4B, 8'h00};
  localparam logic [7:0] RV [11] = '{8'h08, 8'h00, 8'h00, 8'h50, 8'h41, 8'hD3, 8'hAC,
                                     8'hD3, 8'hAC, 8'h00, 8'h00};
  localparam logic [7:0] E2 [4] = '{8'h00, 8'h00, 8'h10, 8'h00};
  localparam logic [7:0] E3 [4] = '{8'h10, 8'h00, 8'h10, 8'h10};
  logic              mclk_i = 1'b0;
  logic              rst_i = 1'b1;
  mac_pkg::reg_req_t req = '0;
  logic [7:0]        rdata;
  logic [7:0]        meas;
  logic              rvalid;
  logic              active;
  logic              slow;
  logic              short_c;
  logic              sdown;
  logic              alert;
  logic              alert_oe;
  logic [2:0]        chan;
  logic [4:0][7:0]   codes = {8'h19, {4{8'hC0}}};
  int                n_fail = 0;
  int                num_checks = 0;

  initial forever #50 mclk_i = ~mclk_i;

  monitor_alert_control #(.TEMP_CYC(TC), .VOLT_CYC(VC)) monitor_alert_control_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .reg_req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
    .meas_code_i(meas), .conv_chan_o(chan), .conv_active_o(active), .osc_slow_o(slow),
    .short_cycle_o(short_c), .shutdown_o(sdown), .alert_o(alert), .alert_oe_o(alert_oe));

  adc_model adc_model_i (.mclk_i(mclk_i), .conv_chan_i(chan), .conv_active_i(active),
                         .codes_i(codes), .meas_code_o(meas));

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string m);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask : check

  task automatic timeout(input string m);
    n_fail++;
    $display("MISMATCH %0t wait ran out: %s", $time, m);
    summarize();
  endtask : timeout

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tick

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    #1 req = '{1'b1, 1'b0, a, d};
    @(posedge mclk_i);
    #1 req = '0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    int i;
    @(posedge mclk_i);
    #1 req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk_i);
    #1 req = '0;
    for (i = 0; i < 4 && rvalid !== 1'b1; i++) tick(1);
    if (rvalid !== 1'b1) timeout("read answer");
    d = rdata;
  endtask : reg_rd

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string m);
    logic [7:0] d;
    reg_rd(a, d);
    check(d, exp, m);
  endtask : rd_chk

  task automatic wait_chan(input logic [2:0] c, input bit eq);
    int i;
    for (i = 0; i < 500 && ((chan === c) != eq); i++) tick(1);
    if ((chan === c) != eq) timeout("channel sequence");
  endtask : wait_chan

  // Two passes so at least one full loop sees the current codes
  task automatic wait_loop();
    repeat (2) begin
      wait_chan(3'd4, 1'b1);
      wait_chan(3'd4, 1'b0);
    end
    tick(4);
  endtask : wait_loop

  task automatic t_reset();
    for (int i = 0; i < 11; i++) rd_chk(RA[i], RV[i], "reset value");
    check(8'(sdown), 8'h01, "shut down out of reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_run();
    for (int a = 8'h2B; a <= 8'h32; a++) reg_wr(8'(a), a[0] ? 8'hD3 : 8'hAC);
    reg_wr(8'h40, 8'h09);
    tick(2);
    check(8'(sdown), 8'h01, "clear bit holds loop");
    reg_wr(8'h40, 8'h01);
    tick(2);
    check(8'(sdown), 8'h00, "loop started");
    check(8'(active), 8'h01, "loop active");
    wait_chan(3'd4, 1'b1);
    reg_wr(8'h40, 8'h00);
    tick(2);
    check(8'(sdown), 8'h01, "loop stopped");
    check(8'(active), 8'h00, "loop inactive");
    reg_wr(8'h43, 8'h1F);
    rd_chk(8'h43, 8'h1F, "write while shut down");
    reg_wr(8'h43, 8'h00);
    rd_chk(8'h43, 8'h00, "rewrite while shut down");
    $display("test run done");
  endtask : t_run

  task automatic t_window(input logic [7:0] cfg, input int exp);
    int n;
    n = 0;
    reg_wr(8'h40, cfg);
    wait_chan(3'd2, 1'b1);
    wait_chan(3'd0, 1'b1);
    wait_chan(3'd1, 1'b1);
    for (int i = 0; i < 200 && chan === 3'd1; i++) begin
      n++;
      tick(1);
    end
    check(8'(slow), 8'(cfg[4]), "clock select");
    check(8'(short_c), 8'(cfg[5]), "short cycle");
    check(8'(n), 8'(exp), "window length");
    $display("test window %h done", cfg);
  endtask : t_window

  task automatic t_volt();
    reg_wr(8'h40, 8'h03);
    for (int ch = 0; ch < 4; ch++) begin
      // Odd rails go high, even rails go low, so both limits are hit
      codes[ch] = ch[0] ? 8'hF0 : 8'h10;
      wait_loop();
      check(8'(alert_oe), 8'h01, "rail fault alert");
      rd_chk(8'h41, 8'h01 << ch, "rail fault bit");
      tick(3);
      check(8'(alert_oe), 8'h00, "alert cleared by read");
      wait_loop();
      check(8'(alert_oe), 8'h01, "persisting fault reasserts");
      codes[ch] = 8'hC0;
      rd_chk(8'h41, 8'h01 << ch, "fault seen again");
      wait_loop();
      rd_chk(8'h41, 8'h00, "stays clear");
    end
    $display("test volt done");
  endtask : t_volt

  task automatic t_mask();
    reg_wr(8'h43, 8'h02);
    codes[1] = 8'hF0;
    wait_loop();
    check(8'(alert_oe), 8'h00, "masked alert");
    rd_chk(8'h41, 8'h00, "masked status");
    codes[1] = 8'hC0;
    reg_wr(8'h43, 8'h00);
    $display("test mask done");
  endtask : t_mask

  task automatic t_alert();
    reg_wr(8'h40, 8'h01);
    codes[2] = 8'h10;
    wait_loop();
    check(8'(alert_oe), 8'h00, "alert disabled");
    reg_wr(8'h40, 8'h03);
    tick(3);
    check(8'(alert_oe), 8'h01, "alert enabled");
    reg_wr(8'h40, 8'h0B);
    tick(3);
    check(8'(alert_oe), 8'h00, "alert forced off");
    check(8'(sdown), 8'h01, "clear bit stops loop");
    codes[2] = 8'hC0;
    rd_chk(8'h41, 8'h04, "status kept");
    reg_wr(8'h40, 8'h03);
    $display("test alert done");
  endtask : t_alert

  task automatic t_temp();
    logic [7:0] d;
    for (int m = 0; m < 4; m++) begin
      reg_wr(8'h4B, 8'(m));
      codes[4] = 8'h60;
      wait_loop();
      rd_chk(8'h41, 8'h10, "hot flagged");
      rd_chk(8'h41, E2[m], "read while hot");
      wait_loop();
      rd_chk(8'h41, E3[m], "next loop while hot");
      codes[4] = 8'h19;
      wait_loop();
      reg_rd(8'h41, d);
      reg_rd(8'h41, d);
    end
    reg_wr(8'h4B, 8'h00);
    $display("test temp done");
  endtask : t_temp

  task automatic t_srst();
    reg_wr(8'h39, 8'h70);
    reg_wr(8'h43, 8'h1F);
    reg_wr(8'h40, 8'hF3);
    tick(2);
    rd_chk(8'h40, 8'h08, "config restored");
    rd_chk(8'h39, 8'h50, "hot limit restored");
    rd_chk(8'h43, 8'h00, "mask restored");
    check(8'(sdown), 8'h01, "stopped after soft reset");
    $display("test soft reset done");
  endtask : t_srst

  initial begin
    tick(5);
    rst_i = 1'b0;
    t_reset();
    t_run();
    t_window(8'h01, VC);
    t_window(8'h21, VC / 4);
    t_window(8'h11, VC * 614 / 512);
    t_volt();
    t_mask();
    t_alert();
    t_temp();
    t_srst();
    summarize();
  end
endmodule : monitor_alert_control_tb_top
